// ### hdl/itc_top.sv
// interrupt and trap controller with event transfer channels and ahb-lite registers
// How it works
// - answer accepted request within 250 to 600 ns
// - each source picks vectored or channel service
// - vectored service branches to source vector
// - channel service steals exactly one cycle
// - move byte/word, bump source or destination pointer
// - counter decrements unless continuous mode
// - zero count raises source's vectored interrupt
// - eight independent event transfer channels
// - per-source request, enable, four-bit priority
// - only strictly higher priority nests service
// - compare sources trap 10h-1Fh, vectors 40h-7Ch
// - other sources trap 20h-2Fh, vectors 80h-BCh
// - software trap 00h-7Fh at current priority
// - hardware traps unmaskable, each sets flag
// - hardware trap preempts unless cpu level is 0Fh (hardware trap or reset in service)
// - all resets vector 0000h trap 00h
// - class A vectors 0008h, 0010h, 0018h
// - five class B share 0028h, distinct flags
// - stack pointer checked against limits each access
`timescale 1ns/1ps
`default_nettype none
module itc_top
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [itc_pkg::NUM_SRC-1:0] src_event,
  input wire logic soft_reset,
  input wire logic watchdog_overflow,
  input wire logic nmi_request,
  input wire itc_pkg::itc_class_b_type class_b_fault,
  input wire logic stack_access,
  input wire logic [15:0] stack_pointer,
  input wire logic sw_trap,
  input wire logic [6:0] sw_trap_num,
  input wire logic cpu_ack,
  input wire logic svc_return,
  output itc_pkg::itc_vec_req_type vec_req,
  output itc_pkg::itc_xfer_type xfer,
  output logic cpu_stall
);
  // ************************************************************
  // registers and state
  // ************************************************************
  logic [15:0] src_ctrl_reg [itc_pkg::NUM_SRC];
  logic [15:0] ch_ctrl_reg [itc_pkg::NUM_CH];
  logic [15:0] ch_src_reg [itc_pkg::NUM_CH];
  logic [15:0] ch_dst_reg [itc_pkg::NUM_CH];
  logic [15:0] trap_flag_register;
  logic [15:0] stack_upper_limit;
  logic [15:0] stack_lower_limit;
  logic [3:0] cpu_prio_reg;
  logic [3:0] prio_stack_reg [4];
  logic [1:0] depth_reg;
  logic reset_pend_reg;
  logic class_b_pend_reg;
  itc_pkg::itc_state_type state_reg;
  logic [4:0] grant_src_reg;
  logic [2:0] grant_ch_reg;
  logic [11:0] bus_addr_reg;
  logic bus_wr_reg;
  logic bus_rd_reg;

  // ************************************************************
  // helpers
  // ************************************************************
  // vector byte address is four times trap number
  function automatic logic [8:0] vec_of(input logic [6:0] num);
    vec_of = {num, 2'b00};
  endfunction

  function automatic logic [6:0] src_trap(input logic [4:0] idx);
    src_trap = 7'(itc_pkg::TRAP_SRC_BASE + {2'b00, idx});
  endfunction

  // ************************************************************
  // arbitration
  // ************************************************************
  logic [itc_pkg::NUM_SRC-1:0] pend;
  logic [itc_pkg::NUM_SRC*itc_pkg::PRIO_W-1:0] prio_flat;
  logic arb_found;
  logic [4:0] arb_idx;
  logic [3:0] arb_level;
  logic stk_over;
  logic stk_under;
  logic class_a;
  logic class_b;
  logic win_src;
  logic win_chan;
  logic [2:0] win_ch;
  logic cnt_last;
  logic [15:0] wctrl;

  // pending enabled requests with their priorities
  always_comb
  begin
    for (int i = 0; i < itc_pkg::NUM_SRC; i++)
    begin
      pend[i] = src_ctrl_reg[i][itc_pkg::SC_REQ] && src_ctrl_reg[i][itc_pkg::SC_EN];
      prio_flat[i*itc_pkg::PRIO_W +: itc_pkg::PRIO_W] =
        src_ctrl_reg[i][itc_pkg::SC_PRIO_LO +: itc_pkg::PRIO_W];
    end
  end

  itc_arbiter u_arb
  (
    .pend(pend),
    .prio(prio_flat),
    .found(arb_found),
    .index(arb_idx),
    .level(arb_level)
  );

  // limit compares on each stack access
  assign stk_over = stack_access && (stack_pointer < stack_upper_limit);
  assign stk_under = stack_access && (stack_pointer > stack_lower_limit);
  assign class_a = nmi_request || stk_over || stk_under;
  assign class_b = |class_b_fault || class_b_pend_reg;
  // grant only above current cpu level, never above a hardware trap service
  assign win_src = arb_found && (arb_level > cpu_prio_reg) && !class_a && !class_b;
  assign win_chan = win_src && src_ctrl_reg[arb_idx][itc_pkg::SC_CHEN];
  assign win_ch = src_ctrl_reg[arb_idx][itc_pkg::SC_CH_LO +: 3];
  assign cnt_last = ch_ctrl_reg[grant_ch_reg][itc_pkg::CC_CNT_LO +: 8] == 8'h01;

  // ************************************************************
  // service sequencer
  // ************************************************************
  // one vectored request outstanding until cpu acknowledges; traps first
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_reg <= itc_pkg::ST_IDLE;
      vec_req <= '0;
      xfer <= '0;
      cpu_stall <= 1'b0;
      grant_src_reg <= 5'h00;
      grant_ch_reg <= 3'h0;
      cpu_prio_reg <= 4'h0;
      depth_reg <= 2'h0;
      reset_pend_reg <= 1'b1;
      class_b_pend_reg <= 1'b0;
      for (int i = 0; i < 4; i++)
      begin
        prio_stack_reg[i] <= 4'h0;
      end
    end
    else
    begin
      xfer.valid <= 1'b0;
      cpu_stall <= 1'b0;
      class_b_pend_reg <= class_b; // a blocked class b fault waits here
      if (svc_return && depth_reg != 2'h0)
      begin
        depth_reg <= depth_reg - 2'h1;
        cpu_prio_reg <= prio_stack_reg[depth_reg - 2'h1];
      end
      case (state_reg)
        itc_pkg::ST_IDLE:
        begin
          if (reset_pend_reg || soft_reset || watchdog_overflow)
          begin
            reset_pend_reg <= 1'b0;
            vec_req <= {1'b1, itc_pkg::TRAP_RESET, vec_of(itc_pkg::TRAP_RESET), itc_pkg::PRIO_TRAP};
            state_reg <= itc_pkg::ST_VEC;
          end
          else if (class_a && cpu_prio_reg != itc_pkg::PRIO_TRAP)
          begin
            vec_req.valid <= 1'b1;
            vec_req.prio <= itc_pkg::PRIO_TRAP;
            state_reg <= itc_pkg::ST_VEC;
            if (nmi_request)
              vec_req.trap_num <= itc_pkg::TRAP_NMI;
            else if (stk_over)
              vec_req.trap_num <= itc_pkg::TRAP_STK_OVER;
            else
              vec_req.trap_num <= itc_pkg::TRAP_STK_UNDER;
            vec_req.vector <= nmi_request ? vec_of(itc_pkg::TRAP_NMI) :
              (stk_over ? vec_of(itc_pkg::TRAP_STK_OVER) : vec_of(itc_pkg::TRAP_STK_UNDER));
          end
          else if (class_b && cpu_prio_reg != itc_pkg::PRIO_TRAP)
          begin
            vec_req <= {1'b1, itc_pkg::TRAP_CLASS_B, vec_of(itc_pkg::TRAP_CLASS_B), itc_pkg::PRIO_TRAP};
            class_b_pend_reg <= 1'b0;
            state_reg <= itc_pkg::ST_VEC;
          end
          else if (sw_trap)
          begin
            vec_req <= {1'b1, sw_trap_num, vec_of(sw_trap_num), cpu_prio_reg};
            state_reg <= itc_pkg::ST_VEC;
          end
          else if (win_chan)
          begin
            grant_src_reg <= arb_idx;
            grant_ch_reg <= win_ch;
            state_reg <= itc_pkg::ST_XFER;
          end
          else if (win_src)
          begin
            grant_src_reg <= arb_idx;
            vec_req <= {1'b1, src_trap(arb_idx), vec_of(src_trap(arb_idx)), arb_level};
            state_reg <= itc_pkg::ST_VEC;
          end
        end
        itc_pkg::ST_XFER:
        begin
          // single stolen cycle carrying the move
          xfer <= {1'b1, ch_ctrl_reg[grant_ch_reg][itc_pkg::CC_WORD],
            ch_src_reg[grant_ch_reg], ch_dst_reg[grant_ch_reg]};
          cpu_stall <= 1'b1;
          state_reg <= itc_pkg::ST_IDLE;
          if (!ch_ctrl_reg[grant_ch_reg][itc_pkg::CC_CONT] && cnt_last)
          begin
            vec_req <= {1'b1, src_trap(grant_src_reg), vec_of(src_trap(grant_src_reg)),
              src_ctrl_reg[grant_src_reg][itc_pkg::SC_PRIO_LO +: itc_pkg::PRIO_W]};
            state_reg <= itc_pkg::ST_VEC;
          end
        end
        itc_pkg::ST_VEC:
        begin
          // held until taken, well inside the response window
          if (cpu_ack)
          begin
            vec_req.valid <= 1'b0;
            prio_stack_reg[depth_reg] <= cpu_prio_reg;
            depth_reg <= depth_reg + 2'h1;
            cpu_prio_reg <= vec_req.prio;
            state_reg <= itc_pkg::ST_IDLE;
          end
        end
        default:
        begin
          state_reg <= itc_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ************************************************************
  // ahb-lite slave
  // ************************************************************
  logic bus_go;
  assign bus_go = hsel && hready && htrans[1];
  assign wctrl = hwdata[15:0];

  // address phase capture, zero wait state answer
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      bus_addr_reg <= 12'h000;
      bus_wr_reg <= 1'b0;
      bus_rd_reg <= 1'b0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      bus_addr_reg <= haddr[11:0];
      bus_wr_reg <= bus_go && hwrite;
      bus_rd_reg <= bus_go && !hwrite;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // read mux; unmapped reads return zero
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h00000000;
    else if (bus_go && !hwrite)
    begin
      hrdata <= 32'h00000000;
      if (haddr[11:7] == itc_pkg::OFS_SRC_CTRL[11:7])
        hrdata[15:0] <= src_ctrl_reg[haddr[6:2]];
      else if (haddr[11:5] == itc_pkg::OFS_CH_CTRL[11:5])
        hrdata[15:0] <= ch_ctrl_reg[haddr[4:2]];
      else if (haddr[11:5] == itc_pkg::OFS_CH_SRC[11:5])
        hrdata[15:0] <= ch_src_reg[haddr[4:2]];
      else if (haddr[11:5] == itc_pkg::OFS_CH_DST[11:5])
        hrdata[15:0] <= ch_dst_reg[haddr[4:2]];
      else if (haddr[11:0] == itc_pkg::OFS_TRAP_FLAGS)
        hrdata[15:0] <= trap_flag_register;
      else if (haddr[11:0] == itc_pkg::OFS_STK_UPPER)
        hrdata[15:0] <= stack_upper_limit;
      else if (haddr[11:0] == itc_pkg::OFS_STK_LOWER)
        hrdata[15:0] <= stack_lower_limit;
      else if (haddr[11:0] == itc_pkg::OFS_CPU_PRIO)
        hrdata[3:0] <= cpu_prio_reg;
      else if (haddr[11:0] == itc_pkg::OFS_STATUS)
        hrdata[7:0] <= {state_reg, depth_reg, 4'h0};
    end
  end

  // ************************************************************
  // source control: request set by event beats clear
  // ************************************************************
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      for (int i = 0; i < itc_pkg::NUM_SRC; i++)
        src_ctrl_reg[i] <= 16'h0000;
    end
    else
    begin
      for (int i = 0; i < itc_pkg::NUM_SRC; i++)
      begin
        if (bus_wr_reg && bus_addr_reg[11:7] == itc_pkg::OFS_SRC_CTRL[11:7] &&
            bus_addr_reg[6:2] == 5'(i))
          src_ctrl_reg[i] <= wctrl;
        // grant clears the request
        if (state_reg == itc_pkg::ST_IDLE && win_src && !reset_pend_reg &&
            !soft_reset && !watchdog_overflow && !sw_trap && arb_idx == 5'(i))
          src_ctrl_reg[i][itc_pkg::SC_REQ] <= 1'b0;
        if (src_event[i])
          src_ctrl_reg[i][itc_pkg::SC_REQ] <= 1'b1;
      end
    end
  end

  // ************************************************************
  // channel registers: count and pointer update per transfer
  // ************************************************************
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      for (int c = 0; c < itc_pkg::NUM_CH; c++)
      begin
        ch_ctrl_reg[c] <= 16'h0000;
        ch_src_reg[c] <= 16'h0000;
        ch_dst_reg[c] <= 16'h0000;
      end
    end
    else
    begin
      for (int c = 0; c < itc_pkg::NUM_CH; c++)
      begin
        if (bus_wr_reg && bus_addr_reg[4:2] == 3'(c))
        begin
          if (bus_addr_reg[11:5] == itc_pkg::OFS_CH_CTRL[11:5])
            ch_ctrl_reg[c] <= wctrl;
          if (bus_addr_reg[11:5] == itc_pkg::OFS_CH_SRC[11:5])
            ch_src_reg[c] <= wctrl;
          if (bus_addr_reg[11:5] == itc_pkg::OFS_CH_DST[11:5])
            ch_dst_reg[c] <= wctrl;
        end
        if (state_reg == itc_pkg::ST_XFER && grant_ch_reg == 3'(c))
        begin
          if (!ch_ctrl_reg[c][itc_pkg::CC_CONT])
            ch_ctrl_reg[c][itc_pkg::CC_CNT_LO +: 8] <=
              ch_ctrl_reg[c][itc_pkg::CC_CNT_LO +: 8] - 8'h01;
          if (ch_ctrl_reg[c][itc_pkg::CC_INC_DST])
            ch_dst_reg[c] <= ch_dst_reg[c] + (ch_ctrl_reg[c][itc_pkg::CC_WORD] ? 16'h0002 : 16'h0001);
          else
            ch_src_reg[c] <= ch_src_reg[c] + (ch_ctrl_reg[c][itc_pkg::CC_WORD] ? 16'h0002 : 16'h0001);
        end
      end
    end
  end

  // ************************************************************
  // trap flags and stack limits; hardware set beats write-clear
  // ************************************************************
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      trap_flag_register <= 16'h0000;
      stack_upper_limit <= 16'h0000;
      stack_lower_limit <= 16'hffff;
    end
    else
    begin
      if (bus_wr_reg && bus_addr_reg == itc_pkg::OFS_TRAP_FLAGS)
        trap_flag_register <= trap_flag_register & wctrl;
      if (bus_wr_reg && bus_addr_reg == itc_pkg::OFS_STK_UPPER)
        stack_upper_limit <= wctrl;
      if (bus_wr_reg && bus_addr_reg == itc_pkg::OFS_STK_LOWER)
        stack_lower_limit <= wctrl;
      if (nmi_request)
        trap_flag_register[itc_pkg::TF_NMI] <= 1'b1;
      if (stk_over)
        trap_flag_register[itc_pkg::TF_STK_OVER] <= 1'b1;
      if (stk_under)
        trap_flag_register[itc_pkg::TF_STK_UNDER] <= 1'b1;
      if (class_b_fault.undef_op)
        trap_flag_register[itc_pkg::TF_UNDEF_OP] <= 1'b1;
      if (class_b_fault.prot_fault)
        trap_flag_register[itc_pkg::TF_PROT] <= 1'b1;
      if (class_b_fault.ill_operand)
        trap_flag_register[itc_pkg::TF_ILL_OPER] <= 1'b1;
      if (class_b_fault.ill_instr)
        trap_flag_register[itc_pkg::TF_ILL_INSTR] <= 1'b1;
      if (class_b_fault.ill_bus)
        trap_flag_register[itc_pkg::TF_ILL_BUS] <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// ### hdl/itc_pkg.sv
// package of constants and carriers for the interrupt and trap controller
package itc_pkg;
  localparam int unsigned NUM_SRC = 32;
  localparam int unsigned NUM_CH = 8;
  localparam int unsigned PRIO_W = 4;
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned RESP_MIN_NS = 250;
  localparam int unsigned RESP_MAX_NS = 600;
  localparam int unsigned RESP_MIN_CYC = (RESP_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned RESP_MAX_CYC = (RESP_MAX_NS * CLK_MHZ) / 1000;
  localparam logic [6:0] TRAP_RESET = 7'h00;
  localparam logic [6:0] TRAP_NMI = 7'h02;
  localparam logic [6:0] TRAP_STK_OVER = 7'h04;
  localparam logic [6:0] TRAP_STK_UNDER = 7'h06;
  localparam logic [6:0] TRAP_CLASS_B = 7'h0a;
  localparam logic [6:0] TRAP_SRC_BASE = 7'h10;
  localparam logic [3:0] PRIO_TRAP = 4'hf;
  // register byte offsets
  localparam logic [11:0] OFS_SRC_CTRL = 12'h000;
  localparam logic [11:0] OFS_CH_CTRL = 12'h080;
  localparam logic [11:0] OFS_CH_SRC = 12'h0a0;
  localparam logic [11:0] OFS_CH_DST = 12'h0c0;
  localparam logic [11:0] OFS_TRAP_FLAGS = 12'h100;
  localparam logic [11:0] OFS_STK_UPPER = 12'h104;
  localparam logic [11:0] OFS_STK_LOWER = 12'h108;
  localparam logic [11:0] OFS_CPU_PRIO = 12'h10c;
  localparam logic [11:0] OFS_STATUS = 12'h110;
  // source control field positions
  localparam int unsigned SC_REQ = 7;
  localparam int unsigned SC_EN = 6;
  localparam int unsigned SC_CHEN = 5;
  localparam int unsigned SC_CH_LO = 8;
  localparam int unsigned SC_PRIO_LO = 0;
  // channel control field positions
  localparam int unsigned CC_CNT_LO = 0;
  localparam int unsigned CC_WORD = 8;
  localparam int unsigned CC_INC_DST = 9;
  localparam int unsigned CC_CONT = 10;
  // trap flag bit positions
  localparam int unsigned TF_NMI = 15;
  localparam int unsigned TF_STK_OVER = 14;
  localparam int unsigned TF_STK_UNDER = 13;
  localparam int unsigned TF_UNDEF_OP = 7;
  localparam int unsigned TF_ILL_OPER = 3;
  localparam int unsigned TF_ILL_INSTR = 2;
  localparam int unsigned TF_ILL_BUS = 1;
  localparam int unsigned TF_PROT = 0;

  typedef struct packed {
    logic undef_op;
    logic prot_fault;
    logic ill_operand;
    logic ill_instr;
    logic ill_bus;
  } itc_class_b_type;

  typedef struct packed {
    logic valid;
    logic [6:0] trap_num;
    logic [8:0] vector;
    logic [3:0] prio;
  } itc_vec_req_type;

  typedef struct packed {
    logic valid;
    logic word;
    logic [15:0] src_ptr;
    logic [15:0] dst_ptr;
  } itc_xfer_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_VEC = 2'b01,
    ST_XFER = 2'b10
  } itc_state_type;
endpackage

// ### hdl/itc_arbiter.sv
// priority arbiter picking the highest pending enabled source
`timescale 1ns/1ps
`default_nettype none
module itc_arbiter
(
  input wire logic [itc_pkg::NUM_SRC-1:0] pend,
  input wire logic [itc_pkg::NUM_SRC*itc_pkg::PRIO_W-1:0] prio,
  output logic found,
  output logic [4:0] index,
  output logic [3:0] level
);
  // scan low index first, later strictly higher level wins
  always_comb
  begin
    found = 1'b0;
    index = 5'h00;
    level = 4'h0;
    for (int i = 0; i < itc_pkg::NUM_SRC; i++)
    begin
      if (pend[i] && (!found || prio[i*itc_pkg::PRIO_W +: itc_pkg::PRIO_W] > level))
      begin
        found = 1'b1;
        index = 5'(i);
        level = prio[i*itc_pkg::PRIO_W +: itc_pkg::PRIO_W];
      end
    end
  end
endmodule
`default_nettype wire

// ### verification/itc_props.sv
// checker of the controller's port behaviour
`timescale 1ns/1ps
`default_nettype none
module itc_props
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic nmi_request,
  input wire logic cpu_ack,
  input wire itc_pkg::itc_vec_req_type vec_req,
  input wire itc_pkg::itc_xfer_type xfer,
  input wire logic cpu_stall
);
  localparam int RESP_MAX = 120;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ****
  // assertions
  // ****
  reset_vec_a: assert property (
    $rose(hresetn) |-> ##[0:2] (vec_req.valid && vec_req.trap_num == 7'h00))
    else $error("no reset vector after reset");
  vec_hold_a: assert property (
    vec_req.valid && !cpu_ack |=> vec_req.valid && $stable(vec_req))
    else $error("vector request dropped before ack");
  vec_align_a: assert property (
    vec_req.valid |-> vec_req.vector == {vec_req.trap_num, 2'b00})
    else $error("vector not four times trap number");
  trap_prio_a: assert property (
    vec_req.valid && vec_req.trap_num inside {7'h02, 7'h04, 7'h06, 7'h0a}
    |-> vec_req.prio == 4'hf)
    else $error("hardware trap below top priority");
  nmi_resp_a: assert property (
    $rose(nmi_request) |-> ##[1:RESP_MAX] (vec_req.valid && vec_req.trap_num == 7'h02))
    else $error("nmi not answered in time");
  xfer_stall_a: assert property (xfer.valid |-> cpu_stall)
    else $error("transfer without stall");
  stall_src_a: assert property (cpu_stall |-> xfer.valid)
    else $error("stall without transfer");
  xfer_pulse_a: assert property (xfer.valid |=> !xfer.valid && !cpu_stall)
    else $error("transfer longer than one cycle");
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus not ready or error");
  cover property (xfer.valid);
  cover property (vec_req.valid && cpu_ack && vec_req.trap_num == 7'h0a);
  cover property (vec_req.valid && cpu_ack && vec_req.trap_num == 7'h02);
endmodule
bind itc_top itc_props u_props (.hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout),
  .hresp(hresp), .nmi_request(nmi_request), .cpu_ack(cpu_ack), .vec_req(vec_req),
  .xfer(xfer), .cpu_stall(cpu_stall));
`default_nettype wire

// ### verification/itc_cpu_model.sv
// behavioural cpu that takes vectors and returns from services
`timescale 1ns/1ps
`default_nettype none
module itc_cpu_model
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire itc_pkg::itc_vec_req_type vec_req,
  input wire logic [3:0] ack_delay,
  output logic cpu_ack,
  output logic svc_return
);
  // take a request after a chosen delay, serve briefly, then return
  initial
  begin
    cpu_ack = 1'b0;
    svc_return = 1'b0;
    forever
    begin
      @(posedge hclk);
      if (hresetn && vec_req.valid)
      begin
        repeat (ack_delay) @(posedge hclk);
        cpu_ack <= 1'b1;
        @(posedge hclk);
        cpu_ack <= 1'b0;
        repeat (3) @(posedge hclk);
        svc_return <= 1'b1;
        @(posedge hclk);
        svc_return <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ### verification/interrupt_and_trap_controller_tb.sv
// self-checking bench of the interrupt and trap controller
`timescale 1ns/1ps
`default_nettype none
module interrupt_and_trap_controller_tb;
  logic hclk = 1'b0, hresetn, hsel, hwrite, hreadyout, hresp, cpu_stall, cpu_ack, svc_return;
  logic soft_reset, watchdog_overflow, nmi_request, stack_access, sw_trap;
  logic [31:0] haddr, hwdata, hrdata, src_event, q;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [15:0] stack_pointer;
  logic [6:0] sw_trap_num, t;
  logic [3:0] ack_delay, p;
  itc_pkg::itc_class_b_type class_b_fault;
  itc_pkg::itc_vec_req_type vec_req;
  itc_pkg::itc_xfer_type xfer;
  logic [19:0] got_q[$];
  logic [32:0] xf_q[$];
  int mismatches = 0, total_checks = 0, fb[5] = '{7, 0, 3, 2, 1};
  int unsigned seed = 58;
  always #2.5 hclk = ~hclk;
  itc_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .src_event(src_event), .soft_reset(soft_reset),
    .watchdog_overflow(watchdog_overflow), .nmi_request(nmi_request),
    .class_b_fault(class_b_fault), .stack_access(stack_access),
    .stack_pointer(stack_pointer), .sw_trap(sw_trap), .sw_trap_num(sw_trap_num),
    .cpu_ack(cpu_ack), .svc_return(svc_return), .vec_req(vec_req), .xfer(xfer),
    .cpu_stall(cpu_stall));
  itc_cpu_model u_cpu (.hclk(hclk), .hresetn(hresetn), .vec_req(vec_req),
    .ack_delay(ack_delay), .cpu_ack(cpu_ack), .svc_return(svc_return));
  // record every taken vector and every transfer
  always @(posedge hclk)
  begin
    if (vec_req.valid === 1'b1 && cpu_ack === 1'b1)
      got_q.push_back({vec_req.trap_num, vec_req.vector, vec_req.prio});
    if (xfer.valid === 1'b1)
      xf_q.push_back({xfer.word, xfer.src_ptr, xfer.dst_ptr});
  end
  // ****
  // helpers
  // ****
  function automatic int unsigned rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task check(input logic [32:0] seen, input logic [32:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task time_out();
    mismatches++;
    $display("wrong value at %0t: wait ran out", $time);
    tally_and_finish();
  endtask
  task wait_rdy();
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1)
    begin
      n++;
      if (n > 50) time_out();
      @(posedge hclk);
    end
  endtask
  task ahb(input logic w, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {20'h0, a};
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy();
    q = hrdata;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    ahb(1'b1, a, d);
  endtask
  task rd_chk(input logic [11:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0);
    check(33'(q), 33'(e));
  endtask
  task wait_q(input int x);
    int n;
    n = 0;
    while ((x ? xf_q.size() : got_q.size()) == 0)
    begin
      n++;
      if (n > 300) time_out();
      @(posedge hclk);
    end
  endtask
  task exp_vec(input logic [6:0] tn, input logic [3:0] pr);
    wait_q(0);
    check(33'(got_q.pop_front()), 33'({tn, tn, 2'b00, pr}));
  endtask
  task exp_xfer(input logic [15:0] s, input logic [15:0] d);
    wait_q(1);
    check(xf_q.pop_front(), {1'b0, s, d});
  endtask
  task pulse_src(input int i);
    @(posedge hclk);
    src_event <= 32'h1 << i;
    @(posedge hclk);
    src_event <= 32'h0;
  endtask
  // ****
  // main sequence
  // ****
  initial
  begin
    {hresetn, hsel, hwrite, soft_reset, watchdog_overflow, nmi_request} = '0;
    {stack_access, sw_trap, haddr, hwdata, src_event, htrans, stack_pointer} = '0;
    {sw_trap_num, ack_delay, class_b_fault} = '0;
    hsize = 3'b010;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    exp_vec(7'h00, 4'hf);
    rd_chk(itc_pkg::OFS_STK_UPPER, 32'h0);
    rd_chk(itc_pkg::OFS_STK_LOWER, 32'h0000ffff);
    rd_chk(12'h200, 32'h0);
    // every source vectored at a random priority
    for (int i = 0; i < 32; i++)
    begin
      p = 4'(1 + rnd() % 14);
      ack_delay <= 4'(rnd() % 8);
      wr(12'(4 * i), 32'h40 | 32'(p));
      pulse_src(i);
      exp_vec(7'(16 + i), p);
    end
    wr(12'h01c, 32'h43);
    wr(12'h050, 32'h49);
    @(posedge hclk);
    src_event <= 32'h0010_0080;
    @(posedge hclk);
    src_event <= 32'h0;
    exp_vec(7'h24, 4'h9);
    exp_vec(7'h17, 4'h3);
    // each channel counts two byte transfers, then vectors its source
    for (int c = 0; c < 8; c++)
    begin
      wr(12'(32 + 4 * c), 32'h64 | 32'(c << 8));
      wr(12'(128 + 4 * c), 32'h2 | 32'((c % 2) << 9));
      wr(12'(160 + 4 * c), 32'h1000 + 32'(c * 16));
      wr(12'(192 + 4 * c), 32'h2000 + 32'(c * 16));
      for (int k = 0; k < 2; k++)
      begin
        pulse_src(8 + c);
        exp_xfer(16'(32'h1000 + c * 16 + k * (1 - c % 2)),
          16'(32'h2000 + c * 16 + k * (c % 2)));
      end
      exp_vec(7'(24 + c), 4'h4);
      rd_chk(12'(128 + 4 * c), 32'((c % 2) << 9));
    end
    wr(12'h18, 32'h0365);
    wr(12'h08c, 32'h0401);
    wr(12'h0ac, 32'h3000);
    wr(12'h0cc, 32'h4000);
    for (int k = 0; k < 2; k++)
    begin
      pulse_src(6);
      exp_xfer(16'(32'h3000 + k), 16'h4000);
    end
    rd_chk(12'h08c, 32'h0401);
    check(33'(got_q.size()), 33'h0);
    // class a traps and their flags
    @(posedge hclk);
    nmi_request <= 1'b1;
    @(posedge hclk);
    nmi_request <= 1'b0;
    exp_vec(7'h02, 4'hf);
    rd_chk(itc_pkg::OFS_TRAP_FLAGS, 32'h8000);
    wr(itc_pkg::OFS_TRAP_FLAGS, 32'h0);
    wr(itc_pkg::OFS_STK_UPPER, 32'h0100);
    wr(itc_pkg::OFS_STK_LOWER, 32'h0300);
    for (int k = 0; k < 2; k++)
    begin
      @(posedge hclk);
      stack_access <= 1'b1;
      stack_pointer <= k ? 16'h0400 : 16'h0080;
      @(posedge hclk);
      stack_access <= 1'b0;
      exp_vec(7'(4 + 2 * k), 4'hf);
      rd_chk(itc_pkg::OFS_TRAP_FLAGS, 32'h4000 >> k);
      wr(itc_pkg::OFS_TRAP_FLAGS, 32'h0);
    end
    wr(itc_pkg::OFS_STK_UPPER, 32'h0);
    wr(itc_pkg::OFS_STK_LOWER, 32'hffff);
    // class b traps share one vector with distinct flags
    for (int j = 0; j < 6; j++)
    begin
      @(posedge hclk);
      class_b_fault <= itc_pkg::itc_class_b_type'(5'h10 >> (j % 5));
      nmi_request <= (j == 5);
      @(posedge hclk);
      class_b_fault <= '0;
      nmi_request <= 1'b0;
      if (j == 5) exp_vec(7'h02, 4'hf);
      exp_vec(7'h0a, 4'hf);
      rd_chk(itc_pkg::OFS_TRAP_FLAGS, (j == 5) ? 32'h8080 : 32'h1 << fb[j]);
      wr(itc_pkg::OFS_TRAP_FLAGS, 32'h0);
    end
    // software traps at the current priority
    for (int k = 0; k < 4; k++)
    begin
      t = 7'(48 + rnd() % 80);
      @(posedge hclk);
      sw_trap <= 1'b1;
      sw_trap_num <= t;
      @(posedge hclk);
      sw_trap <= 1'b0;
      exp_vec(t, 4'h0);
    end
    // software reset, watchdog, then a second hardware reset
    for (int k = 0; k < 3; k++)
    begin
      @(posedge hclk);
      soft_reset <= (k == 0);
      watchdog_overflow <= (k == 1);
      hresetn <= (k != 2);
      repeat (2) @(posedge hclk);
      {soft_reset, watchdog_overflow, hresetn} <= 3'b001;
      exp_vec(7'h00, 4'hf);
    end
    tally_and_finish();
  end
endmodule
`default_nettype wire
